// file: bench/acts_seq_props.sv
module acts_seq_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // tester pins and routing
    input wire logic test_select,
    input wire logic test_clock,
    input wire logic [acts_pkg::CHANNELS-1:0] tx_switch_en,
    input wire logic [acts_pkg::CHANNELS-1:0] rx_switch_en,
    input wire logic normal_mode,
    input wire logic test_active,
    input wire logic sequence_done,
    input wire logic [acts_pkg::EDGE_W-1:0] edge_count
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // routing properties
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_onehot; $onehot0({tx_switch_en, rx_switch_en}); endproperty
    property p_quiet; test_select [*5] |-> !test_active; endproperty
    property p_start; $rose(test_active) |-> edge_count == 5'h01; endproperty
    property p_tx0; $rose(edge_count == 5'h02) |=> tx_switch_en == 14'h0001 && !normal_mode; endproperty
    property p_rx0; $rose(edge_count == 5'h11) |=> rx_switch_en == 14'h0001 && tx_switch_en == 14'h0000; endproperty
    property p_back;
        $rose(test_select) |-> ##[1:6] normal_mode && rx_switch_en == 14'h0000 && tx_switch_en == 14'h0000;
    endproperty
    // decode register lags the counter by one clock
    property p_txstep;
        test_active && edge_count > 5'h02 && edge_count < 5'h10 ##1 test_active
        |-> tx_switch_en == 14'h0001 << ($past(edge_count) - 5'h02);
    endproperty
    property p_rxstep;
        test_active && edge_count > 5'h11 && edge_count < 5'h1F ##1 test_active
        |-> rx_switch_en == 14'h0001 << ($past(edge_count) - 5'h11);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one pin pair routed");
    a_quiet: assert property (p_quiet) else $error("sequence active with select high");
    a_start: assert property (p_start) else $error("sequence did not start at edge one");
    a_tx0: assert property (p_tx0) else $error("transmit channel 0 not routed");
    a_rx0: assert property (p_rx0) else $error("receive channel 0 not routed");
    a_back: assert property (p_back) else $error("normal connection not restored");
    a_txstep: assert property (p_txstep) else $error("wrong transmit channel");
    a_rxstep: assert property (p_rxstep) else $error("wrong receive channel");
    c_done: cover property (sequence_done);
    c_rx13: cover property (rx_switch_en[13]);
    c_back: cover property ($rose(normal_mode));
endmodule

bind acts_seq acts_seq_props acts_seq_props_inst (.clk(clk), .rst_n(rst_n), .test_select(test_select),
    .test_clock(test_clock), .tx_switch_en(tx_switch_en), .rx_switch_en(rx_switch_en), .normal_mode(normal_mode),
    .test_active(test_active), .sequence_done(sequence_done), .edge_count(edge_count));

// file: bench/acts_seq_tb_top.sv
module acts_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic test_select, test_clock, normal_mode, test_active, sequence_done;
    logic [acts_pkg::CHANNELS-1:0] tx, rx;
    logic [acts_pkg::EDGE_W-1:0] edge_count;
    logic [28:0] last;
    logic [28:0] notes[$];
    int err_total = 0;
    int checks_done = 0;
    int runs[3] = '{30, 32, 33};
    always #5 clk = ~clk;
    acts_tester acts_tester_inst (.clk(clk), .test_select(test_select), .test_clock(test_clock));
    acts_seq acts_seq_inst (.clk(clk), .rst_n(rst_n), .test_select(test_select), .test_clock(test_clock),
        .tx_switch_en(tx), .rx_switch_en(rx), .normal_mode(normal_mode), .test_active(test_active),
        .sequence_done(sequence_done), .edge_count(edge_count));
    // ----
    // checking
    // ----
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s exp=%h seen=%h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // every routing change must match the oldest note
    always @(posedge clk)
    begin
        if (rst_n && {normal_mode, rx, tx} !== last)
            check("routing", {normal_mode, rx, tx}, notes.size() ? notes.pop_front() : 'x);
        last <= {normal_mode, rx, tx};
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
    initial
    begin
        void'($urandom(92));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("reset_state", {normal_mode, tx, rx, test_active, sequence_done, edge_count},
            36'h8_0000_0000);
        acts_tester_inst.pulses(4);
        check("idle_select", {test_active, edge_count}, 36'h0);
        $display("edges with select high done");
        foreach (runs[i])
        begin
            acts_tester_inst.slow = (i == 2);
            // edge 1 only leaves normal mode, edge 16 is the gap between the halves
            for (int k = 1; k <= runs[i] && k <= 30; k++)
                notes.push_back(k == 1 || k == 16 ? 29'h0 : k <= 15 ? 29'h1 << (k - 2) : 29'h1 << (k - 3));
            notes.push_back(29'h1000_0000);
            acts_tester_inst.start();
            acts_tester_inst.pulses(runs[i]);
            check("run_status", {test_active, sequence_done, edge_count},
                {1'b1, runs[i] >= 30, runs[i] > 30 ? 5'h1E : 5'(runs[i])});
            acts_tester_inst.stop();
            $display("run of %0d pulses done", runs[i]);
        end
        check("notes_left", notes.size(), 36'h0);
        close_out();
    end
endmodule

// file: bench/acts_tester.sv
module acts_tester (
    // bench clock
    input wire logic clk,
    // tester pins
    output logic test_select,
    output logic test_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // board tester
    // ----
    int slow = 0;
    initial
    begin
        test_select = 1'b1;
        test_clock = 1'b1;
    end
    // test clock idles high between frames; halves stay above 3 clk or edges are lost
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk) test_clock <= 1'b0;
            repeat (5 + (slow ? $urandom % 4 : 0)) @(posedge clk);
            test_clock <= 1'b1;
            repeat (5 + i % 2 + (slow ? $urandom % 4 : 0)) @(posedge clk);
        end
    endtask
    task automatic start();
        @(posedge clk) test_select <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic stop();
        @(posedge clk) test_select <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: rtl/acts_pkg.sv
package acts_pkg;
    // ------------------------------------------------------------
    // sequence geometry
    // ------------------------------------------------------------
    localparam int unsigned CHANNELS = 14;
    localparam int unsigned CH_W = 4;
    localparam int unsigned EDGE_W = 5;
    // falling test-clock edges counted from test-select going low
    localparam logic [EDGE_W-1:0] EDGE_RESET = 5'h01;
    localparam logic [EDGE_W-1:0] EDGE_TX_FIRST = 5'h02;
    localparam logic [EDGE_W-1:0] EDGE_RX_FIRST = 5'h11;
    localparam logic [EDGE_W-1:0] EDGE_LAST = 5'h1E;
    localparam logic [CH_W-1:0] CH_RESET = 4'h0;
    localparam logic [EDGE_W-1:0] EDGE_COUNT_RESET = 5'h00;

    typedef enum logic [1:0] {
        ACTS_IDLE,
        ACTS_ARMED,
        ACTS_TX,
        ACTS_RX
    } acts_state_t;
endpackage

// file: rtl/acts_sel_if.sv
// selection bundle from the sequencer to the analog switch matrix decoder
interface acts_sel_if;
    logic test_active;
    logic sel_valid;
    logic sel_receive;
    logic [acts_pkg::CH_W-1:0] sel_channel;

    modport ctrl (output test_active, output sel_valid, output sel_receive, output sel_channel);
    modport mux (input test_active, input sel_valid, input sel_receive, input sel_channel);
endinterface

// file: rtl/acts_seq.sv
// Contract
// - mux logic, clocked by test clock, reset by test-select, routes each channel's pins; the code runs on clk and counts sampled test-clock edges.
// - sequence starts when test-select is driven low with the test clock running.
// - first falling test-clock edge after select low resets counter and selection.
// - second falling edge routes transmit channel 0 onto the test outputs.
// - seventeenth falling edge routes receive channel 0 onto the test outputs.
// - select may return high after edge thirty; then all channels go normal.
module acts_seq (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // test pins from the board tester
    input wire logic test_select,
    input wire logic test_clock,
    // analog routing control
    output logic [acts_pkg::CHANNELS-1:0] tx_switch_en,
    output logic [acts_pkg::CHANNELS-1:0] rx_switch_en,
    output logic normal_mode,
    // sequence status
    output logic test_active,
    output logic sequence_done,
    output logic [acts_pkg::EDGE_W-1:0] edge_count
);
    // --------------------------------------------------------------
    // sequencer state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sel_sync;
        logic [1:0] tck_sync;
        logic tck_prev;
        acts_pkg::acts_state_t state;
        logic [acts_pkg::EDGE_W-1:0] edges;
        logic [acts_pkg::CH_W-1:0] channel;
        logic done;
    } acts_seq_t;

    // select idles high, so a board with no tester attached never starts a sequence;
    // tck_prev starts low so no falling edge can be seen in the first cycles
    localparam acts_seq_t SEQ_RESET = '{
        sel_sync: 2'h3,
        tck_sync: 2'h0,
        tck_prev: 1'b0,
        state: acts_pkg::ACTS_IDLE,
        edges: acts_pkg::EDGE_COUNT_RESET,
        channel: acts_pkg::CH_RESET,
        done: 1'b0
    };

    acts_seq_t s_q;
    acts_seq_t s_d;

    // pin events
    logic tck_fall;
    logic sel_low;

    // position within the sequence
    logic [acts_pkg::EDGE_W-1:0] edges_next;
    logic [acts_pkg::CH_W-1:0] channel_next;
    logic at_first;
    logic at_tx_first;
    logic at_rx_first;
    logic at_last;

    // selection handed to the switch decoder
    logic seq_idle;
    logic in_tx;
    logic in_rx;
    logic routing;
    logic channel_ok;

    // the bundle stays inside the block; the top keeps plain ports
    acts_sel_if sel_bus ();

    // --------------------------------------------------------------
    // pin sampling
    // --------------------------------------------------------------
    // the test clock is far slower than clk, so two-flop sampling is enough to count it;
    // a level held for less than three clk periods may be lost
    // edges are found on the second stage only; the first stage feeds nothing else
    assign tck_fall = s_q.tck_prev && !s_q.tck_sync[1];
    assign sel_low = !s_q.sel_sync[1];

    // --------------------------------------------------------------
    // sequence position
    // --------------------------------------------------------------
    // falling test-clock edges counted while select is low:
    //   1       counter and selection cleared, nothing routed
    //   2..15   transmit pins of channels 0..13
    //   16      gap: channel code 14 matches no switch
    //   17..30  receive pins of channels 0..13
    //   31 on   receive channel 13 stays routed
    // the count saturates, so a tester that keeps clocking never wraps into a second pass
    assign edges_next = (s_q.edges == acts_pkg::EDGE_LAST) ? s_q.edges : s_q.edges + 1'b1;
    assign channel_next = s_q.channel + 1'b1;
    assign at_first = (edges_next == acts_pkg::EDGE_RESET);
    assign at_tx_first = (edges_next == acts_pkg::EDGE_TX_FIRST);
    assign at_rx_first = (edges_next == acts_pkg::EDGE_RX_FIRST);
    assign at_last = (edges_next == acts_pkg::EDGE_LAST);

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // select is a level; it also serves as the synchronous reset of the sequence
        s_d.sel_sync = {s_q.sel_sync[0], test_select};
        s_d.tck_sync = {s_q.tck_sync[0], test_clock};
        s_d.tck_prev = s_q.tck_sync[1];
        if (!sel_low)
        begin
            // select high acts as the sequencer's reset
            s_d.state = acts_pkg::ACTS_IDLE;
            s_d.edges = acts_pkg::EDGE_COUNT_RESET;
            s_d.channel = acts_pkg::CH_RESET;
            s_d.done = 1'b0;
        end
        else if (tck_fall)
        begin
            s_d.edges = edges_next;
            unique case (s_q.state)
                acts_pkg::ACTS_IDLE:
                begin
                    // the first counted edge only clears; nothing is routed yet
                    if (at_first)
                    begin
                        s_d.state = acts_pkg::ACTS_ARMED;
                    end
                    s_d.channel = acts_pkg::CH_RESET;
                end

                acts_pkg::ACTS_ARMED:
                begin
                    // edge two hands transmit channel 0 to the switches
                    if (at_tx_first)
                    begin
                        s_d.state = acts_pkg::ACTS_TX;
                    end
                    s_d.channel = acts_pkg::CH_RESET;
                end

                acts_pkg::ACTS_TX:
                begin
                    // edge seventeen opens the receive half
                    if (at_rx_first)
                    begin
                        s_d.state = acts_pkg::ACTS_RX;
                        s_d.channel = acts_pkg::CH_RESET;
                    end
                    else
                    begin
                        // after channel 13 the code steps to 14, which closes no switch
                        s_d.channel = channel_next;
                    end
                end

                acts_pkg::ACTS_RX:
                begin
                    // no step once the count has saturated
                    if (s_q.edges != acts_pkg::EDGE_LAST)
                    begin
                        s_d.channel = channel_next;
                    end
                    // last receive channel stays routed until select returns
                    s_d.done = at_last;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    // one register for all state keeps the reset image and the clocking in one place
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= SEQ_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // routing
    // --------------------------------------------------------------
    // routing is offered only while the synchronised select is low, so a return to normal cuts it at once;
    // the decoder adds one register, so the switches follow the count one clk later
    assign seq_idle = (s_q.state == acts_pkg::ACTS_IDLE);
    assign in_tx = (s_q.state == acts_pkg::ACTS_TX);
    assign in_rx = (s_q.state == acts_pkg::ACTS_RX);
    assign routing = sel_low && (in_tx || in_rx);
    assign channel_ok = (s_q.channel < acts_pkg::CHANNELS);
    assign sel_bus.test_active = sel_low && !seq_idle;
    assign sel_bus.sel_valid = routing && channel_ok;
    assign sel_bus.sel_receive = in_rx;
    assign sel_bus.sel_channel = s_q.channel;

    acts_switch_decode u_decode (
        .clk(clk),
        .rst_n(rst_n),
        .sel(sel_bus),
        .tx_switch_en(tx_switch_en),
        .rx_switch_en(rx_switch_en),
        .normal_mode(normal_mode)
    );

    // --------------------------------------------------------------
    // status
    // --------------------------------------------------------------
    // edge_count stands at thirty once saturated, and sequence_done holds until select returns high;
    // a second start needs select high for at least three clk so the sampler sees it
    assign test_active = sel_bus.test_active;
    assign sequence_done = s_q.done;
    assign edge_count = s_q.edges;
endmodule

// file: rtl/acts_switch_decode.sv
// registered one-hot switch enables for the analog test multiplexer
module acts_switch_decode (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // selection
    acts_sel_if.mux sel,
    // switch enables
    output logic [acts_pkg::CHANNELS-1:0] tx_switch_en,
    output logic [acts_pkg::CHANNELS-1:0] rx_switch_en,
    output logic normal_mode
);
    typedef struct packed {
        logic [acts_pkg::CHANNELS-1:0] tx;
        logic [acts_pkg::CHANNELS-1:0] rx;
        logic normal;
    } acts_dec_t;

    acts_dec_t s_q;
    acts_dec_t s_d;
    logic [acts_pkg::CHANNELS-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < acts_pkg::CHANNELS; g++)
        begin : g_ch
            assign hit[g] = sel.sel_valid && (sel.sel_channel == g[acts_pkg::CH_W-1:0]);
        end
    endgenerate

    always_comb
    begin
        s_d.tx = sel.sel_receive ? '0 : hit;
        s_d.rx = sel.sel_receive ? hit : '0;
        // leaving test mode drops every switch at once
        s_d.normal = !sel.test_active;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{tx: '0, rx: '0, normal: 1'b1};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tx_switch_en = s_q.tx;
    assign rx_switch_en = s_q.rx;
    assign normal_mode = s_q.normal;
endmodule
